// ---- pvs_pkg.sv ----
// constants, register map and encodings for the pcm voice slot interface
// assumes a single 25 MHz system clock and a plain one-cycle register port
package pvs_pkg;
  localparam int unsigned PVS_NUM_CH = 3;
  localparam int unsigned PVS_WORD_W = 16;
  localparam int unsigned PVS_SAMPLE_W = 13;
  localparam int unsigned PVS_BUF_BYTES = 1040;
  localparam int unsigned PVS_SLOT_W = 5;
  localparam int unsigned PVS_BIT_W = 9;
  localparam int unsigned PVS_LONG_SYNC_BITS = 3;
  // register indices on the 4-bit port
  localparam logic [3:0] PVS_A_CTRL = 4'h0;
  localparam logic [3:0] PVS_A_FMT = 4'h1;
  localparam logic [3:0] PVS_A_CHAN = 4'h2;
  localparam logic [3:0] PVS_A_STAT = 4'h3;
  localparam logic [3:0] PVS_A_TX0 = 4'h4;
  localparam logic [3:0] PVS_A_RX0 = 4'h7;
  localparam logic [3:0] PVS_A_BUFPTR = 4'ha;
  localparam logic [3:0] PVS_A_TXBUF = 4'hb;
  localparam logic [3:0] PVS_A_RXBUF = 4'hc;
  // ctrl: [0] enable [1] master [2] long sync [5:3] rate [7:6] mode [15:8] half period
  localparam logic [15:0] PVS_CTRL_RST = 16'h0100;
  // fmt: [1:0] field lsb position [2] lsb first [4:3] fill [7:5] fill value
  localparam logic [1:0] PVS_POS_RST = 2'h3;
  localparam logic [7:0] PVS_FMT_RST = 8'h03;
  localparam logic [2:0] PVS_RATE_MAX = 3'h4;
  typedef enum logic [1:0] {PVS_NARROW, PVS_TRANSP, PVS_WIDE, PVS_MODE_RSV} pvs_mode_t;
  typedef enum logic [1:0] {PVS_FILL_ZERO, PVS_FILL_ONE, PVS_FILL_SIGN, PVS_FILL_PROG} pvs_fill_t;
endpackage : pvs_pkg

// ---- pvs_pcm_voice_slot_interface.sv ----
// pcm voice slot interface: slot engine, formatter, staging buffers, register port
// assumes pcm pins come from outside the clock domain; bit clock well below clk/4
`timescale 1ns/10ps
module pvs_pcm_voice_slot_interface import pvs_pkg::*; #(
  parameter int unsigned BUF_BYTES = PVS_BUF_BYTES
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic pcm_bclk_in,
  output logic pcm_bclk_out,
  output logic pcm_bclk_oe_out,
  input wire logic pcm_sync_in,
  output logic pcm_sync_out,
  output logic pcm_sync_oe_out,
  input wire logic pcm_din_in,
  output logic pcm_dout_out,
  output logic pcm_dout_oe_out
);
  localparam int unsigned AW = $clog2(BUF_BYTES);

  function automatic logic [15:0] pvs_fmt_tx(input logic [15:0] s, input logic [7:0] f);
    logic [15:0] w;
    int p;
    int k;
    w = '0;
    p = int'(f[1:0]);
    for (int i = 0; i < 16; i++) begin
      k = (i < p) ? i : i - 13;
      if (i >= p && i < p + 13) begin
        w[i] = s[i-p];
      end else begin
        unique case (pvs_fill_t'(f[4:3]))
          PVS_FILL_ZERO: w[i] = 1'b0;
          PVS_FILL_ONE: w[i] = 1'b1;
          PVS_FILL_SIGN: w[i] = s[12];
          PVS_FILL_PROG: w[i] = f[5+k];
        endcase
      end
    end
    return w;
  endfunction : pvs_fmt_tx

  logic bclk_s1_r, bclk_s2_r, bclk_s3_r, sync_s1_r, sync_s2_r, din_s1_r, din_s2_r;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [7:0] fmt_r, fmt_nxt;
  logic [17:0] chan_r, chan_nxt;
  logic [15:0] tx_r [PVS_NUM_CH];
  logic [15:0] tx_nxt [PVS_NUM_CH];
  logic [15:0] rx_r [PVS_NUM_CH];
  logic [15:0] rx_nxt [PVS_NUM_CH];
  logic [2:0] rx_full_r, rx_full_nxt, tx_empty_r, tx_empty_nxt;
  logic [AW-1:0] ptr_r, ptr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] div_r, div_nxt;
  logic mbclk_r, mbclk_nxt, fs_r, fs_nxt, dout_r, dout_nxt, oe_r, oe_nxt;
  logic bclk_oe_r, bclk_oe_nxt, sync_prev_r, sync_prev_nxt, hit_r, hit_nxt;
  logic [PVS_BIT_W-1:0] bit_r, bit_nxt, pend_r, pend_nxt;
  logic [15:0] txsh_r, txsh_nxt, rxsh_r, rxsh_nxt;
  logic [1:0] ch_r, ch_nxt;
  logic [7:0] txbuf [BUF_BYTES];
  logic [7:0] rxbuf [BUF_BYTES];

  logic en, master, long_sync, lsb_first, rise, fall, tick, sync_lvl, raw, srch_hit;
  logic [2:0] rate, slot_log;
  logic [PVS_BIT_W-1:0] frame_last;
  logic [1:0] srch_ch;
  logic [3:0] bp_r, bp_p, idx_r, idx_p;
  logic [15:0] word, rxw;

  always_comb begin
    en = ctrl_r[0];
    master = ctrl_r[1];
    long_sync = ctrl_r[2];
    lsb_first = fmt_r[2];
    rate = (ctrl_r[5:3] > PVS_RATE_MAX) ? PVS_RATE_MAX : ctrl_r[5:3];
    raw = (pvs_mode_t'(ctrl_r[7:6]) == PVS_TRANSP) || (pvs_mode_t'(ctrl_r[7:6]) == PVS_WIDE);
    // slot count is a power of two: fs 4 kHz doubles it, 16 kHz halves it but never below one slot (rate 0 stays at one)
    unique case (pvs_mode_t'(ctrl_r[7:6]))
      PVS_TRANSP: slot_log = rate + 3'h1;
      PVS_WIDE: slot_log = (rate == 3'h0) ? 3'h0 : rate - 3'h1;
      default: slot_log = rate;
    endcase
    frame_last = PVS_BIT_W'((16 << slot_log) - 1);
    tick = master && en && (div_r == 8'h00);
    rise = master ? (tick && !mbclk_r) : (bclk_s2_r && !bclk_s3_r);
    fall = master ? (tick && mbclk_r) : (!bclk_s2_r && bclk_s3_r);
    sync_lvl = master ? fs_r : sync_s2_r;
    bp_r = bit_r[3:0];
    bp_p = pend_r[3:0];
    idx_r = lsb_first ? bp_r : 4'hf - bp_r;
    idx_p = lsb_first ? bp_p : 4'hf - bp_p;
    srch_hit = 1'b0;
    srch_ch = 2'h0;
    for (int c = PVS_NUM_CH - 1; c >= 0; c--) begin
      if (chan_r[6*c+5] && (chan_r[6*c +: 5] == pend_r[8:4])
          && ({4'h0, chan_r[6*c +: 5]} <= (frame_last >> 4))) begin
        srch_hit = 1'b1;
        srch_ch = 2'(c);
      end
    end
    word = raw ? tx_r[srch_ch] : pvs_fmt_tx(tx_r[srch_ch], fmt_r);
    rxw = rxsh_r;
    rxw[idx_r] = din_s2_r;
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    fmt_nxt = fmt_r;
    chan_nxt = chan_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    rx_full_nxt = rx_full_r;
    tx_empty_nxt = tx_empty_r;
    ptr_nxt = ptr_r;
    rdata_nxt = 32'h0;
    div_nxt = div_r;
    mbclk_nxt = mbclk_r;
    fs_nxt = fs_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    bit_nxt = bit_r;
    pend_nxt = pend_r;
    txsh_nxt = txsh_r;
    rxsh_nxt = rxsh_r;
    ch_nxt = ch_r;
    hit_nxt = hit_r;
    sync_prev_nxt = sync_prev_r;
    bclk_oe_nxt = en && master;
    // software clears first so a same-cycle hardware set overrides it
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        PVS_A_CTRL: rdata_nxt = {16'h0, ctrl_r};
        PVS_A_FMT: rdata_nxt = {24'h0, fmt_r};
        PVS_A_CHAN: rdata_nxt = {14'h0, chan_r};
        PVS_A_STAT: rdata_nxt = {16'h0, bit_r, oe_r, tx_empty_r, rx_full_r};
        PVS_A_BUFPTR: rdata_nxt = 32'(ptr_r);
        PVS_A_TXBUF: rdata_nxt = {24'h0, txbuf[ptr_r]};
        PVS_A_RXBUF: rdata_nxt = {24'h0, rxbuf[ptr_r]};
        default: rdata_nxt = 32'h0;
      endcase
      for (int c = 0; c < PVS_NUM_CH; c++) begin
        if (reg_addr_in == PVS_A_TX0 + 4'(c)) rdata_nxt = {16'h0, tx_r[c]};
        if (reg_addr_in == PVS_A_RX0 + 4'(c)) begin
          rdata_nxt = {16'h0, rx_r[c]};
          rx_full_nxt[c] = 1'b0;
        end
      end
    end
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        PVS_A_CTRL: ctrl_nxt = reg_wdata_in[15:0];
        PVS_A_FMT: fmt_nxt = reg_wdata_in[7:0];
        PVS_A_CHAN: chan_nxt = reg_wdata_in[17:0];
        PVS_A_BUFPTR: ptr_nxt = reg_wdata_in[AW-1:0];
        default: ;
      endcase
      for (int c = 0; c < PVS_NUM_CH; c++) begin
        if (reg_addr_in == PVS_A_TX0 + 4'(c)) begin
          tx_nxt[c] = reg_wdata_in[15:0];
          tx_empty_nxt[c] = 1'b0;
        end
      end
    end
    if ((reg_wr_in || reg_rd_in) && (reg_addr_in == PVS_A_TXBUF || reg_addr_in == PVS_A_RXBUF)) begin
      ptr_nxt = (ptr_r == AW'(BUF_BYTES - 1)) ? '0 : ptr_r + 1'b1;
    end
    if (tick || !en || !master) begin
      div_nxt = ctrl_r[15:8];
    end else begin
      div_nxt = div_r - 8'h01;
    end
    if (tick) mbclk_nxt = !mbclk_r;
    if (!en) begin
      mbclk_nxt = 1'b0;
      fs_nxt = 1'b0;
      oe_nxt = 1'b0;
      hit_nxt = 1'b0;
    end else if (rise) begin
      bit_nxt = pend_r;
      if (master) begin
        fs_nxt = long_sync ? (pend_r < PVS_BIT_W'(PVS_LONG_SYNC_BITS))
                           : (pend_r == frame_last);
      end
      if (bp_p == 4'h0) begin
        hit_nxt = srch_hit;
        ch_nxt = srch_ch;
        if (srch_hit) begin
          txsh_nxt = word;
          tx_empty_nxt[srch_ch] = 1'b1;
          dout_nxt = word[idx_p];
        end
        oe_nxt = srch_hit;
      end else begin
        oe_nxt = hit_r;
        dout_nxt = txsh_r[idx_p];
      end
    end else if (fall) begin
      sync_prev_nxt = sync_lvl;
      if (!long_sync && sync_lvl) begin
        pend_nxt = '0;
      end else if (long_sync && sync_lvl && !sync_prev_r) begin
        pend_nxt = PVS_BIT_W'(1);
      end else begin
        pend_nxt = (bit_r >= frame_last) ? '0 : bit_r + 1'b1;
      end
      if (hit_r) begin
        rxsh_nxt = rxw;
        if (bp_r == 4'hf) begin
          rx_nxt[ch_r] = raw ? rxw : {{3{rxw[int'(fmt_r[1:0]) + 12]}},
                                     13'(rxw >> fmt_r[1:0])};
          rx_full_nxt[ch_r] = 1'b1;
        end
      end
      if (bp_r == 4'hf) oe_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    bclk_s1_r <= pcm_bclk_in;
    bclk_s2_r <= bclk_s1_r;
    bclk_s3_r <= bclk_s2_r;
    sync_s1_r <= pcm_sync_in;
    sync_s2_r <= sync_s1_r;
    din_s1_r <= pcm_din_in;
    din_s2_r <= din_s1_r;
    // staging memories are uninitialised; no reset keeps them in block ram
    if (reg_wr_in && reg_addr_in == PVS_A_TXBUF) txbuf[ptr_r] <= reg_wdata_in[7:0];
    if (reg_wr_in && reg_addr_in == PVS_A_RXBUF) rxbuf[ptr_r] <= reg_wdata_in[7:0];
    if (!rst_n_in) begin
      ctrl_r <= PVS_CTRL_RST;
      fmt_r <= PVS_FMT_RST;
      chan_r <= '0;
      for (int c = 0; c < PVS_NUM_CH; c++) begin
        tx_r[c] <= '0;
        rx_r[c] <= '0;
      end
      rx_full_r <= '0;
      tx_empty_r <= 3'h7;
      ptr_r <= '0;
      rdata_r <= '0;
      div_r <= '0;
      mbclk_r <= 1'b0;
      fs_r <= 1'b0;
      dout_r <= 1'b0;
      oe_r <= 1'b0;
      bclk_oe_r <= 1'b0;
      bit_r <= '0;
      pend_r <= '0;
      txsh_r <= '0;
      rxsh_r <= '0;
      ch_r <= '0;
      hit_r <= 1'b0;
      sync_prev_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      fmt_r <= fmt_nxt;
      chan_r <= chan_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      rx_full_r <= rx_full_nxt;
      tx_empty_r <= tx_empty_nxt;
      ptr_r <= ptr_nxt;
      rdata_r <= rdata_nxt;
      div_r <= div_nxt;
      mbclk_r <= mbclk_nxt;
      fs_r <= fs_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      bclk_oe_r <= bclk_oe_nxt;
      bit_r <= bit_nxt;
      pend_r <= pend_nxt;
      txsh_r <= txsh_nxt;
      rxsh_r <= rxsh_nxt;
      ch_r <= ch_nxt;
      hit_r <= hit_nxt;
      sync_prev_r <= sync_prev_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign pcm_bclk_out = mbclk_r;
  assign pcm_bclk_oe_out = bclk_oe_r;
  assign pcm_sync_out = fs_r;
  assign pcm_sync_oe_out = bclk_oe_r;
  assign pcm_dout_out = dout_r;
  assign pcm_dout_oe_out = oe_r;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  master_drive_a: assert property (##1 pcm_bclk_oe_out == $past(en && master))
    else $error("clock drive does not follow master enable");
  slot_count_a: assert property (pvs_mode_t'(ctrl_r[7:6]) == PVS_NARROW
    |-> frame_last == PVS_BIT_W'((16 << rate) - 1)) else $error("narrow slot count wrong");
  wide_count_a: assert property (pvs_mode_t'(ctrl_r[7:6]) == PVS_WIDE && rate == 3'h4
    |-> frame_last == PVS_BIT_W'(127)) else $error("wide slot count wrong");
  idle_release_a: assert property (en && rise && bp_p == 4'h0 && !srch_hit
    |=> !pcm_dout_oe_out) else $error("output driven in unassigned slot");
  last_release_a: assert property (en && fall && !rise && bp_r == 4'hf
    |=> !pcm_dout_oe_out) else $error("no release after last bit");
  short_sync_a: assert property (master && !long_sync && pcm_sync_out
    |-> bit_r == frame_last) else $error("short sync outside last bit");
  long_sync_a: assert property (master && long_sync && en && rise ##1 pcm_sync_out
    |-> bit_r < PVS_BIT_W'(3)) else $error("long sync beyond three bits");
  reset_fmt_a: assert property ($past(!rst_n_in) |-> fmt_r[1:0] == PVS_POS_RST
    && !fmt_r[2]) else $error("format not left justified msb first after reset");
  fill_one_a: assert property (pvs_fill_t'(fmt_r[4:3]) == PVS_FILL_ONE && fmt_r[1:0] == 2'h3
    |-> (pvs_fmt_tx(tx_r[0], fmt_r) & 16'h0007) == 16'h0007) else $error("ones fill wrong");

  master_short_c: cover property (master && !long_sync && $rose(pcm_sync_out));
  slave_long_c: cover property (!master && long_sync && en && fall && sync_lvl && !sync_prev_r);
  rx_word_c: cover property ($rose(rx_full_r[2]));
  slot_drive_c: cover property ($rose(pcm_dout_oe_out) ##[1:200] $fell(pcm_dout_oe_out));
endmodule : pvs_pcm_voice_slot_interface

// ---- pvs_codec_model.sv ----
// behavioural pcm master/codec facing the voice slot interface
// assumes the block is slave; bit period 320 ns, short sync only
`timescale 1ns/10ps
module pvs_codec_model (
  input wire logic run_in,
  input wire logic [4:0] slots_in,
  input wire logic [15:0] word_in,
  input wire logic dout_in,
  input wire logic dout_oe_in,
  output logic bclk_out,
  output logic sync_out,
  output logic din_out,
  output logic [3:0][15:0] cap_out,
  output logic [3:0] oe_seen_out,
  output int frames_out
);
  int b;
  initial begin
    bclk_out = 1'b0;
    sync_out = 1'b0;
    din_out = 1'b0;
    cap_out = '0;
    oe_seen_out = 4'h0;
    frames_out = 0;
    forever begin
      wait (run_in);
      oe_seen_out = 4'h0;
      frames_out = 0;
      // lone sync bit so the first frame starts aligned
      bclk_out = 1'b1;
      sync_out = 1'b1;
      #160 bclk_out = 1'b0;
      #160;
      while (run_in) begin
        for (b = 0; b < 16 * int'(slots_in); b++) begin
          bclk_out = 1'b1;
          sync_out = (b == 16 * int'(slots_in) - 1);
          din_out = word_in[15 - b % 16];
          #160 bclk_out = 1'b0;
          // sampled late in the low half: the block reacts a few clocks after each edge
          #100 cap_out[b / 16][15 - b % 16] = dout_in;
          if (dout_oe_in) oe_seen_out[b / 16] = 1'b1;
          #60;
        end
        frames_out++;
      end
      // clock stands still between runs
      din_out = ~din_out;
    end
  end
endmodule : pvs_codec_model

// ---- test_pcm_voice_slot_interface.sv ----
// self-checking bench for the pcm voice slot interface
// assumes pvs_pkg and the codec model are compiled first
`timescale 1ns/10ps
module test_pcm_voice_slot_interface import pvs_pkg::*;;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic bclk_o, bclk_oe, sync_o, sync_oe, dout, dout_oe;
  logic run = 1'b0;
  logic [4:0] slots = 5'h1;
  logic [15:0] word = 16'h0;
  logic m_bclk, m_sync, m_din;
  logic [3:0][15:0] cap;
  logic [3:0] oe_seen;
  int frames;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  pvs_pcm_voice_slot_interface #(.BUF_BYTES(16)) DUT (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .pcm_bclk_in(bclk_oe ? bclk_o : m_bclk),
    .pcm_bclk_out(bclk_o), .pcm_bclk_oe_out(bclk_oe),
    .pcm_sync_in(sync_oe ? sync_o : m_sync), .pcm_sync_out(sync_o),
    .pcm_sync_oe_out(sync_oe), .pcm_din_in(m_din), .pcm_dout_out(dout),
    .pcm_dout_oe_out(dout_oe));
  pvs_codec_model u_codec (
    .run_in(run), .slots_in(slots), .word_in(word), .dout_in(dout),
    .dout_oe_in(dout_oe), .bclk_out(m_bclk), .sync_out(m_sync), .din_out(m_din),
    .cap_out(cap), .oe_seen_out(oe_seen), .frames_out(frames));
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge clk_sys_in);
  endtask : rd_chk
  task automatic t_reset;
    rd_chk(PVS_A_CTRL, 32'h0000_0100);
    rd_chk(PVS_A_FMT, 32'h0000_0003);
    rd_chk(PVS_A_STAT, 32'h0000_0038);
    rd_chk(4'hd, 32'h0);
  endtask : t_reset
  task automatic t_slot(input int slot, input logic [2:0] rate, input logic [7:0] fmt,
                        input logic [15:0] exp_tx);
    int i;
    logic [15:0] w;
    w = 16'ha5a7;
    wr(PVS_A_FMT, 32'(fmt));
    wr(PVS_A_CHAN, 32'(slot) | 32'h20);
    wr(PVS_A_TX0, 32'h0b5c);
    wr(PVS_A_CTRL, 32'h0101 | (32'(rate) << 3));
    slots <= 5'(1 << rate);
    word <= w;
    run <= 1'b1;
    // one edge so the model has restarted its frame count
    @(posedge clk_sys_in);
    for (i = 0; i < 5000 && frames < 3; i++) @(posedge clk_sys_in);
    run <= 1'b0;
    // let one more whole frame pass so the capture is clean
    for (i = 0; i < 5000 && frames < 4; i++) @(posedge clk_sys_in);
    chk(32'(cap[slot]), {16'h0, exp_tx});
    chk(32'(oe_seen), 32'h1 << slot);
    rd_chk(PVS_A_RX0, {16'h0, {3{w[15]}}, w[15:3]});
    wr(PVS_A_CTRL, 32'h0100);
    wr(PVS_A_FMT, 32'h0003);
  endtask : t_slot
  task automatic t_master(input logic lng);
    int i;
    int n;
    wr(PVS_A_CTRL, 32'h0103 | (32'(lng) << 2));
    // skip a pulse that may be cut short by the counter left from before
    for (i = 0; i < 2000 && sync_o !== 1'b1; i++) @(negedge clk_sys_in);
    for (i = 0; i < 2000 && sync_o === 1'b1; i++) @(negedge clk_sys_in);
    for (i = 0; i < 2000 && sync_o !== 1'b1; i++) @(negedge clk_sys_in);
    chk(32'(bclk_oe & sync_oe), 32'h1);
    n = 0;
    while (sync_o === 1'b1 && n < 100) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(32'(n), lng ? 32'd12 : 32'd4);
    @(posedge clk_sys_in);
    wr(PVS_A_CTRL, 32'h0100);
  endtask : t_master
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    t_reset();
    t_slot(0, 3'h0, 8'h03, 16'h5ae0);
    t_slot(1, 3'h1, 8'h03, 16'h5ae0);
    t_slot(3, 3'h2, 8'h03, 16'h5ae0);
    t_slot(0, 3'h0, 8'h0b, 16'h5ae7);
    t_master(1'b0);
    t_master(1'b1);
    summarize();
  end
endmodule : test_pcm_voice_slot_interface
